/* File: rtl/gpc_pin_ctrl.sv */
// gpc_pin_ctrl: supply-level select, pin readback, input enables and pin 0 output control
`timescale 1ns/1ps
module gpc_pin_ctrl
   import gpc_pkg::*;
#(
   parameter int NUM_PINS   = 8,
   parameter int NUM_RX     = 4,
   parameter int NUM_REMOTE = 4,
   parameter int NUM_TX     = 2
)
(
   input  wire logic                         core_clk_in,
   input  wire logic                         reset_in,
   // register port
   input  wire logic [7:0]                   reg_addr_in,
   input  wire logic [7:0]                   reg_wdata_in,
   input  wire logic                         reg_write_in,
   input  wire logic                         reg_read_in,
   output logic      [7:0]                   reg_rdata_out,
   // pins and supply detection
   input  wire logic [NUM_PINS-1:0]          pin_level_in,
   input  wire logic                         io_level_detect_in,
   output logic                              io_high_voltage_select_out,
   output logic      [1:0]                   io_supply_mode_out,
   output logic      [NUM_PINS-1:0]          pin_input_enable_out,
   output logic                              pin0_data_out,
   output logic                              pin0_oe_n_out,
   // status from receivers and transmit ports, same clock
   input  wire logic [NUM_RX*NUM_REMOTE-1:0] rx_remote_pin_in,
   input  wire logic [NUM_RX-1:0]            rx_lock_in,
   input  wire logic [NUM_RX-1:0]            rx_pass_in,
   input  wire logic [NUM_RX-1:0]            rx_frame_valid_in,
   input  wire logic [NUM_RX-1:0]            rx_line_valid_in,
   input  wire logic [NUM_RX-1:0]            rx_port_enable_in,
   input  wire logic                         frame_sync_in,
   input  wire logic [NUM_TX-1:0]            tx_pass_and_in,
   input  wire logic [NUM_TX-1:0]            tx_pass_or_in,
   input  wire logic [NUM_TX-1:0]            tx_frame_valid_in,
   input  wire logic [NUM_TX-1:0]            tx_line_valid_in,
   input  wire logic [NUM_TX-1:0]            tx_synced_in,
   input  wire logic [NUM_TX-1:0]            tx_interrupt_in
);

   // software-held control fields
   logic                io_high_voltage_select_q;
   logic                io_supply_override_q;
   logic [1:0]          io_supply_mode_q;
   logic [NUM_PINS-1:0] pin_input_enable_q;
   logic [2:0]          pin0_output_select_q;
   logic [2:0]          pin0_output_source_q;
   logic                pin0_output_value_q;
   logic                pin0_output_drive_enable_q;

   // pin side registers
   logic                pin0_data_q;
   logic                pin0_oe_n_q;
   logic [7:0]          rdata_q;

   // synchronised pin levels and detected supply
   logic [NUM_PINS-1:0] pin_level_s;
   logic                io_level_detect_s;

   // pins and the supply detector are outside this clock domain
   gpc_sync2 #(
      .WIDTH (NUM_PINS + 1)
   ) u_pin_sync (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .async_in    ({io_level_detect_in, pin_level_in}),
      .sync_out    ({io_level_detect_s, pin_level_s})
   );

   // address decode
   wire hit_io  = (reg_addr_in == GPC_OFS_IO_VOLTAGE_CONTROL);
   wire hit_pin = (reg_addr_in == GPC_OFS_PIN_LEVEL_READBACK);
   wire hit_ie  = (reg_addr_in == GPC_OFS_PIN_INPUT_ENABLES);
   wire hit_p0  = (reg_addr_in == GPC_OFS_PIN0_OUTPUT_CONTROL);
   wire wr_io   = reg_write_in && hit_io;
   wire wr_ie   = reg_write_in && hit_ie;
   wire wr_p0   = reg_write_in && hit_p0;

   // effective supply controls: detector unless software overrides
   wire       detect_3v3     = io_level_detect_s;
   wire [1:0] detect_mode    = detect_3v3 ? GPC_SUPPLY_MODE_3V3 : GPC_SUPPLY_MODE_1V8;
   wire       eff_high_volt  = io_supply_override_q ? io_high_voltage_select_q : detect_3v3;
   wire [1:0] eff_supply_mod = io_supply_override_q ? io_supply_mode_q : detect_mode;

   // a pin whose input is disabled reads low; the readback is the gated level
   wire [NUM_PINS-1:0] pin_level_snapshot = pin_level_s & pin_input_enable_q;

   // io_voltage_control write side; reserved bits are not stored
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         io_high_voltage_select_q <= GPC_RST_HIGH_VOLTAGE_SELECT;
         io_supply_override_q     <= GPC_RST_SUPPLY_OVERRIDE;
         io_supply_mode_q         <= GPC_RST_SUPPLY_MODE;
      end
      else if (wr_io)
      begin
         io_high_voltage_select_q <= reg_wdata_in[GPC_POS_IO_HIGH_VOLTAGE_SELECT];
         io_supply_override_q     <= reg_wdata_in[GPC_POS_IO_SUPPLY_OVERRIDE];
         io_supply_mode_q         <= reg_wdata_in[GPC_POS_IO_SUPPLY_MODE_HI:GPC_POS_IO_SUPPLY_MODE_LO];
      end
   end

   // input enables, all on after reset so every pin can be read at once
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
         pin_input_enable_q <= GPC_RST_INPUT_ENABLES[NUM_PINS-1:0];
      else if (wr_ie)
         pin_input_enable_q <= reg_wdata_in[NUM_PINS-1:0];
   end

   // pin0_output_control fields
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         pin0_output_select_q       <= GPC_RST_PIN0_SELECT;
         pin0_output_source_q       <= GPC_RST_PIN0_SOURCE;
         pin0_output_value_q        <= GPC_RST_PIN0_VALUE;
         pin0_output_drive_enable_q <= GPC_RST_PIN0_DRIVE_EN;
      end
      else if (wr_p0)
      begin
         pin0_output_select_q       <= reg_wdata_in[GPC_POS_PIN0_SELECT_HI:GPC_POS_PIN0_SELECT_LO];
         pin0_output_source_q       <= reg_wdata_in[GPC_POS_PIN0_SOURCE_HI:GPC_POS_PIN0_SOURCE_LO];
         pin0_output_value_q        <= reg_wdata_in[GPC_POS_PIN0_VALUE];
         pin0_output_drive_enable_q <= reg_wdata_in[GPC_POS_PIN0_DRIVE_EN];
      end
   end

   // read word selection; unmapped offsets read as zero
   wire [7:0] rd_io = {eff_high_volt, io_supply_override_q, eff_supply_mod, GPC_IO_RESERVED_VALUE};
   wire [7:0] rd_ie = 8'(pin_input_enable_q);
   wire [7:0] rd_lv = 8'(pin_level_snapshot);
   wire [7:0] rd_p0 = {pin0_output_select_q, pin0_output_source_q,
                       pin0_output_value_q, pin0_output_drive_enable_q};
   wire [7:0] rd_word = hit_io  ? rd_io :
                        hit_pin ? rd_lv :
                        hit_ie  ? rd_ie :
                        hit_p0  ? rd_p0 : 8'h00;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
         rdata_q <= 8'h00;
      else
         rdata_q <= reg_read_in ? rd_word : 8'h00;
   end

   // source decoding for pin 0
   wire [1:0] rx_idx      = pin0_output_source_q[1:0];
   wire       src_is_rx   = ~pin0_output_source_q[2];
   wire       src_is_dev  = (pin0_output_source_q == GPC_SRC_DEVICE_STATUS);
   wire       src_is_tx   = (pin0_output_source_q == GPC_SRC_TX_PORT0) ||
                            (pin0_output_source_q == GPC_SRC_TX_PORT1);
   wire       tx_idx      = pin0_output_source_q[0];
   wire [2:0] sel         = pin0_output_select_q;

   // receiver source: remote pins by low select bits, else link flags
   wire [$clog2(NUM_RX*NUM_REMOTE)-1:0] remote_idx = {rx_idx, sel[1:0]};
   wire rx_bit = (sel == GPC_RX_SEL_LOCK)        ? rx_lock_in[rx_idx] :
                 (sel == GPC_RX_SEL_PASS)        ? rx_pass_in[rx_idx] :
                 (sel == GPC_RX_SEL_FRAME_VALID) ? rx_frame_valid_in[rx_idx] :
                 (sel == GPC_RX_SEL_LINE_VALID)  ? rx_line_valid_in[rx_idx] :
                 rx_remote_pin_in[remote_idx];

   // device status: only enabled receivers take part; no enabled receiver gives pass low
   wire lock_any = |(rx_lock_in & rx_port_enable_in);
   wire pass_all = (|rx_port_enable_in) && (&(rx_pass_in | ~rx_port_enable_in));
   wire dev_bit  = (sel == GPC_DEV_SEL_VALUE)      ? pin0_output_value_q :
                   (sel == GPC_DEV_SEL_LOCK_OR)    ? lock_any :
                   (sel == GPC_DEV_SEL_PASS_AND)   ? pass_all :
                   (sel == GPC_DEV_SEL_FRAME_SYNC) ? frame_sync_in : 1'b0;

   // transmit port status; reserved codes give low
   wire tx_bit = (sel == GPC_TX_SEL_PASS_AND)    ? tx_pass_and_in[tx_idx] :
                 (sel == GPC_TX_SEL_PASS_OR)     ? tx_pass_or_in[tx_idx] :
                 (sel == GPC_TX_SEL_FRAME_VALID) ? tx_frame_valid_in[tx_idx] :
                 (sel == GPC_TX_SEL_LINE_VALID)  ? tx_line_valid_in[tx_idx] :
                 (sel == GPC_TX_SEL_SYNCED)      ? tx_synced_in[tx_idx] :
                 (sel == GPC_TX_SEL_INTERRUPT)   ? tx_interrupt_in[tx_idx] : 1'b0;

   // the reserved source code drives low rather than an arbitrary flag
   wire pin0_mux = src_is_rx  ? rx_bit :
                   src_is_dev ? dev_bit :
                   src_is_tx  ? tx_bit : 1'b0;

   // data held low while the driver is off, so the pad output is quiet
   wire pin0_data_d = pin0_output_drive_enable_q & pin0_mux;
   wire pin0_oe_n_d = ~pin0_output_drive_enable_q;

   // pin 0 output flops; one cycle behind the selected status
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         pin0_data_q <= 1'b0;
         pin0_oe_n_q <= 1'b1;
      end
      else
      begin
         pin0_data_q <= pin0_data_d;
         pin0_oe_n_q <= pin0_oe_n_d;
      end
   end

   // outputs
   assign reg_rdata_out              = rdata_q;
   assign io_high_voltage_select_out = eff_high_volt;
   assign io_supply_mode_out         = eff_supply_mod;
   assign pin_input_enable_out       = pin_input_enable_q;
   assign pin0_data_out              = pin0_data_q;
   assign pin0_oe_n_out              = pin0_oe_n_q;

   // checks on the block's own outputs
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);

   AST_IO_SELECT_WRITTEN: assert property (
      (wr_io && reg_wdata_in[GPC_POS_IO_SUPPLY_OVERRIDE]) |=>
         io_high_voltage_select_out == $past(reg_wdata_in[GPC_POS_IO_HIGH_VOLTAGE_SELECT]))
      else $error("written high voltage select not applied");

   AST_IO_DETECT_USED: assert property (
      (!io_supply_override_q && $stable(io_level_detect_s)) |->
         (io_high_voltage_select_out == io_level_detect_s) &&
         (io_supply_mode_out == {2{io_level_detect_s}}))
      else $error("detected supply level not used while override clear");

   AST_IO_READ_DETECT: assert property (
      (reg_read_in && hit_io && !io_supply_override_q) |=>
         (reg_rdata_out[7] == $past(io_level_detect_s)) &&
         (reg_rdata_out[5:4] == {2{$past(io_level_detect_s)}}) &&
         (reg_rdata_out[3:0] == GPC_IO_RESERVED_VALUE))
      else $error("supply read does not show detected level");

   AST_LEVEL_READ: assert property (
      (reg_read_in && hit_pin) |=> reg_rdata_out == 8'($past(pin_level_s & pin_input_enable_q)))
      else $error("pin level readback mismatch");

   AST_IE_RESET: assert property (
      @(posedge core_clk_in) disable iff (1'b0)
      reset_in |=> (pin_input_enable_out == GPC_RST_INPUT_ENABLES[NUM_PINS-1:0]) && pin0_oe_n_out)
      else $error("input enables or driver wrong after reset");

   AST_RX_LOCK: assert property (
      (pin0_output_drive_enable_q && src_is_rx && sel == GPC_RX_SEL_LOCK && !wr_p0) |=>
         pin0_data_out == $past(rx_lock_in[rx_idx]))
      else $error("receiver lock not on pin 0");

   AST_DEV_LOCK_OR: assert property (
      (pin0_output_drive_enable_q && src_is_dev && sel == GPC_DEV_SEL_LOCK_OR && !wr_p0) |=>
         pin0_data_out == $past(|(rx_lock_in & rx_port_enable_in)))
      else $error("lock OR of enabled receivers not on pin 0");

   AST_TX_SYNCED: assert property (
      (pin0_output_drive_enable_q && src_is_tx && sel == GPC_TX_SEL_SYNCED && !wr_p0) |=>
         pin0_data_out == $past(tx_synced_in[tx_idx]))
      else $error("transmit synchronized flag not on pin 0");

   AST_REG_VALUE: assert property (
      (wr_p0 && reg_wdata_in[GPC_POS_PIN0_DRIVE_EN] &&
       reg_wdata_in[GPC_POS_PIN0_SOURCE_HI:GPC_POS_PIN0_SOURCE_LO] == GPC_SRC_DEVICE_STATUS &&
       reg_wdata_in[GPC_POS_PIN0_SELECT_HI:GPC_POS_PIN0_SELECT_LO] == GPC_DEV_SEL_VALUE) |=>
         ##1 pin0_data_out == $past(reg_wdata_in[GPC_POS_PIN0_VALUE], 2))
      else $error("output value bit not driven two cycles after write");

   AST_DRIVE_ENABLE: assert property (
      wr_p0 |=> ##1 pin0_oe_n_out == !$past(reg_wdata_in[GPC_POS_PIN0_DRIVE_EN], 2))
      else $error("driver enable does not follow written bit");

   AST_UNDRIVEN: assert property (
      pin0_oe_n_out |-> !pin0_data_out)
      else $error("pin 0 data active while driver is off");

   // register side: written input enables show one cycle after the strobe, a written supply mode only when the override bit is written set
   AST_IO_MODE_WRITTEN: assert property (
      (wr_io && reg_wdata_in[GPC_POS_IO_SUPPLY_OVERRIDE]) |=>
         io_supply_mode_out == $past(reg_wdata_in[GPC_POS_IO_SUPPLY_MODE_HI:GPC_POS_IO_SUPPLY_MODE_LO]))
      else $error("written supply mode not applied");

   AST_IE_WRITTEN: assert property (
      wr_ie |=> pin_input_enable_out == $past(reg_wdata_in[NUM_PINS-1:0]))
      else $error("written input enables not applied");

   AST_RDATA_IDLE: assert property (
      !reg_read_in |=> reg_rdata_out == 8'h00)
      else $error("read data outside the answer cycle");

   // pin 0: the flops follow fields and status one edge later; reserved codes must stay low
   AST_SRC_RESERVED: assert property (
      (pin0_output_source_q == GPC_SRC_RESERVED) |=> !pin0_data_out)
      else $error("reserved source does not drive low");

   AST_RX_REMOTE: assert property (
      (pin0_output_drive_enable_q && src_is_rx && !sel[2]) |=>
         pin0_data_out == $past(rx_remote_pin_in[{rx_idx, sel[1:0]}]))
      else $error("received remote pin not on pin 0");

   AST_RX_LINE_VALID: assert property (
      (pin0_output_drive_enable_q && src_is_rx && sel == GPC_RX_SEL_LINE_VALID) |=>
         pin0_data_out == $past(rx_line_valid_in[rx_idx]))
      else $error("receiver line valid not on pin 0");

   AST_DEV_PASS_AND: assert property (
      (pin0_output_drive_enable_q && src_is_dev && sel == GPC_DEV_SEL_PASS_AND) |=>
         pin0_data_out == $past((rx_port_enable_in != '0) && ((rx_pass_in | ~rx_port_enable_in) == '1)))
      else $error("pass AND of enabled receivers not on pin 0");

   AST_DEV_FRAME_SYNC: assert property (
      (pin0_output_drive_enable_q && src_is_dev && sel == GPC_DEV_SEL_FRAME_SYNC) |=>
         pin0_data_out == $past(frame_sync_in))
      else $error("frame sync not on pin 0");

   AST_DEV_RESERVED: assert property (
      (src_is_dev && sel[2]) |=> !pin0_data_out)
      else $error("reserved device status select does not drive low");

   AST_TX_PASS_AND: assert property (
      (pin0_output_drive_enable_q && src_is_tx && sel == GPC_TX_SEL_PASS_AND) |=>
         pin0_data_out == $past(tx_pass_and_in[tx_idx]))
      else $error("transmit pass AND not on pin 0");

   AST_TX_INTERRUPT: assert property (
      (pin0_output_drive_enable_q && src_is_tx && sel == GPC_TX_SEL_INTERRUPT) |=>
         pin0_data_out == $past(tx_interrupt_in[tx_idx]))
      else $error("transmit interrupt not on pin 0");

   AST_TX_RESERVED: assert property (
      (src_is_tx && sel[2:1] == 2'h3) |=> !pin0_data_out)
      else $error("reserved transmit select does not drive low");

   // a disabled driver must release the pin at the next edge so outside levels can be sensed
   AST_DRIVE_OFF: assert property (
      !pin0_output_drive_enable_q |=> pin0_oe_n_out && !pin0_data_out)
      else $error("pin 0 not released while driver disabled");

endmodule

/* File: rtl/gpc_pkg.sv */
// gpc_pkg: register map, field layout and codes of the pin control block
package gpc_pkg;

   // register offsets on the plain register port
   localparam logic [7:0] GPC_OFS_IO_VOLTAGE_CONTROL  = 8'h0d;
   localparam logic [7:0] GPC_OFS_PIN_LEVEL_READBACK  = 8'h0e;
   localparam logic [7:0] GPC_OFS_PIN_INPUT_ENABLES   = 8'h0f;
   localparam logic [7:0] GPC_OFS_PIN0_OUTPUT_CONTROL = 8'h10;

   // io_voltage_control field positions
   localparam int GPC_POS_IO_HIGH_VOLTAGE_SELECT = 7;
   localparam int GPC_POS_IO_SUPPLY_OVERRIDE     = 6;
   localparam int GPC_POS_IO_SUPPLY_MODE_HI      = 5;
   localparam int GPC_POS_IO_SUPPLY_MODE_LO      = 4;
   localparam int GPC_POS_IO_RESERVED_HI         = 3;

   // pin0_output_control field positions
   localparam int GPC_POS_PIN0_SELECT_HI = 7;
   localparam int GPC_POS_PIN0_SELECT_LO = 5;
   localparam int GPC_POS_PIN0_SOURCE_HI = 4;
   localparam int GPC_POS_PIN0_SOURCE_LO = 2;
   localparam int GPC_POS_PIN0_VALUE     = 1;
   localparam int GPC_POS_PIN0_DRIVE_EN  = 0;

   // reset values
   localparam logic       GPC_RST_HIGH_VOLTAGE_SELECT = 1'b0;
   localparam logic       GPC_RST_SUPPLY_OVERRIDE     = 1'b0;
   localparam logic [1:0] GPC_RST_SUPPLY_MODE         = 2'h0;
   localparam logic [3:0] GPC_IO_RESERVED_VALUE       = 4'h9;
   localparam logic [7:0] GPC_RST_INPUT_ENABLES       = 8'hff;
   localparam logic [2:0] GPC_RST_PIN0_SELECT         = 3'h0;
   localparam logic [2:0] GPC_RST_PIN0_SOURCE         = 3'h0;
   localparam logic       GPC_RST_PIN0_VALUE          = 1'b0;
   localparam logic       GPC_RST_PIN0_DRIVE_EN       = 1'b0;

   // supply mode encodings
   localparam logic [1:0] GPC_SUPPLY_MODE_1V8 = 2'h0;
   localparam logic [1:0] GPC_SUPPLY_MODE_3V3 = 2'h3;

   // output source codes; 000..011 are the link receivers by index
   localparam logic [2:0] GPC_SRC_DEVICE_STATUS = 3'h4;
   localparam logic [2:0] GPC_SRC_RESERVED      = 3'h5;
   localparam logic [2:0] GPC_SRC_TX_PORT0      = 3'h6;
   localparam logic [2:0] GPC_SRC_TX_PORT1      = 3'h7;

   // output select codes, receiver source; 000..011 are remote pins
   localparam logic [2:0] GPC_RX_SEL_LOCK        = 3'h4;
   localparam logic [2:0] GPC_RX_SEL_PASS        = 3'h5;
   localparam logic [2:0] GPC_RX_SEL_FRAME_VALID = 3'h6;
   localparam logic [2:0] GPC_RX_SEL_LINE_VALID  = 3'h7;

   // output select codes, device status source
   localparam logic [2:0] GPC_DEV_SEL_VALUE      = 3'h0;
   localparam logic [2:0] GPC_DEV_SEL_LOCK_OR    = 3'h1;
   localparam logic [2:0] GPC_DEV_SEL_PASS_AND   = 3'h2;
   localparam logic [2:0] GPC_DEV_SEL_FRAME_SYNC = 3'h3;

   // output select codes, transmit port source
   localparam logic [2:0] GPC_TX_SEL_PASS_AND    = 3'h0;
   localparam logic [2:0] GPC_TX_SEL_PASS_OR     = 3'h1;
   localparam logic [2:0] GPC_TX_SEL_FRAME_VALID = 3'h2;
   localparam logic [2:0] GPC_TX_SEL_LINE_VALID  = 3'h3;
   localparam logic [2:0] GPC_TX_SEL_SYNCED      = 3'h4;
   localparam logic [2:0] GPC_TX_SEL_INTERRUPT   = 3'h5;

endpackage

/* File: rtl/gpc_sync2.sv */
// gpc_sync2: two flip-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module gpc_sync2
   import gpc_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             core_clk_in,
   input  wire logic             reset_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // the first stage feeds only the second stage
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

/* File: verification/gpc_pin_partner.sv */
// gpc_pin_partner: outside circuits on the eight pins, with a pull-up on pin 0
`timescale 1ns/1ps
module gpc_pin_partner
(
   input  wire logic       pin0_data_in,
   input  wire logic       pin0_oe_n_in,
   input  wire logic [7:0] ext_level_in,
   input  wire logic       ext_drive0_in,
   output logic      [7:0] pin_level_out
);
   logic pin0_wire;
   // pin 0: device driver first, then the outside driver, else the pull-up holds it high
   assign pin0_wire = !pin0_oe_n_in ? pin0_data_in : (ext_drive0_in ? ext_level_in[0] : 1'b1);
   // pins 1 to 7 are always driven from outside
   assign pin_level_out = {ext_level_in[7:1], pin0_wire};
endmodule

/* File: verification/tb.sv */
// tb: random and corner-case bench for the pin control block
`timescale 1ns/1ps
module tb;
   import gpc_pkg::*;
   logic clk = 0, rst = 1, wrs = 0, rds = 0, det = 0, fsync = 0, ext0 = 1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ien, pins, ext = 8'h00;
   logic hv, p0d, p0oe;
   logic [1:0] mode;
   logic [15:0] remote = 16'h0000;
   logic [3:0] lock = 0, pass = 0, fv = 0, lv = 0, pen = 0;
   logic [1:0] tpa = 0, tpo = 0, tfv = 0, tlv = 0, tsy = 0, tin = 0;
   integer seed = 32'hdc57, n_mismatch = 0, tests_run = 0, s, l, i;
   logic [7:0] e;
   logic v;

   // half period of the 200 MHz clock
   always #2.5 clk = ~clk;

   gpc_pin_ctrl dut_u (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_write_in(wrs), .reg_read_in(rds), .reg_rdata_out(rdata), .pin_level_in(pins),
      .io_level_detect_in(det), .io_high_voltage_select_out(hv), .io_supply_mode_out(mode),
      .pin_input_enable_out(ien), .pin0_data_out(p0d), .pin0_oe_n_out(p0oe), .rx_remote_pin_in(remote),
      .rx_lock_in(lock), .rx_pass_in(pass), .rx_frame_valid_in(fv), .rx_line_valid_in(lv),
      .rx_port_enable_in(pen), .frame_sync_in(fsync), .tx_pass_and_in(tpa), .tx_pass_or_in(tpo),
      .tx_frame_valid_in(tfv), .tx_line_valid_in(tlv), .tx_synced_in(tsy), .tx_interrupt_in(tin));

   gpc_pin_partner far_u (.pin0_data_in(p0d), .pin0_oe_n_in(p0oe), .ext_level_in(ext),
      .ext_drive0_in(ext0), .pin_level_out(pins));

   task close_out;
      begin
         if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   // one compare for every 8-bit or narrower result
   task chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         tests_run++;
         if (got !== exp)
         begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wrs <= 1'b1;
         @(posedge clk);
         wrs <= 1'b0;
      end
   endtask

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [7:0] exp);
      begin
         @(posedge clk);
         addr <= a;
         rds <= 1'b1;
         @(posedge clk);
         rds <= 1'b0;
         #1 chk(rdata, exp);
      end
   endtask

   task rnd_status;
      begin
         @(posedge clk);
         {remote, lock, pass} <= {$random(seed), $random(seed)};
         {fv, lv, pen, fsync} <= $random(seed);
         {tpa, tpo, tfv, tlv, tsy, tin} <= $random(seed);
      end
   endtask

   // what pin 0 should carry for a source, select and value
   function automatic logic exp_pin0(input logic [2:0] src, input logic [2:0] sel, input logic val);
      logic [1:0] r;
      r = src[1:0];
      if (!src[2])
         return sel[2] ? (sel[1] ? (sel[0] ? lv[r] : fv[r]) : (sel[0] ? pass[r] : lock[r])) : remote[4*r+sel[1:0]];
      if (src == 3'h4)
         case (sel)
            3'h0: return val;
            3'h1: return |(lock & pen);
            3'h2: return (pen != 4'h0) && ((pass | ~pen) == 4'hf);
            3'h3: return fsync;
            default: return 1'b0;
         endcase
      if (src == 3'h5 || sel > 3'h5)
         return 1'b0;
      return {tin[src[0]], tsy[src[0]], tlv[src[0]], tfv[src[0]], tpo[src[0]], tpa[src[0]]} >> sel;
   endfunction

   initial
   begin
      #100000;
      n_mismatch++;
      close_out;
   end

   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1 chk(p0oe, 1'b1);
      chk(ien, 8'hff);
      rd(8'h0f, 8'hff);
      rd(8'h10, 8'h00);
      // detected level drives both supply controls while override is clear
      for (i = 0; i < 2; i++)
      begin
         @(posedge clk) det <= i[0];
         repeat (3) @(posedge clk);
         rd(8'h0d, i[0] ? 8'hb9 : 8'h09);
         chk({hv, mode}, i[0] ? 8'h07 : 8'h00);
      end
      wr(8'h0d, 8'hf5);
      det <= 1'b0;
      repeat (3) @(posedge clk);
      rd(8'h0d, 8'hf9);
      chk({hv, mode}, 8'h07);
      wr(8'h0d, 8'h40);
      det <= 1'b1;
      repeat (3) @(posedge clk);
      rd(8'h0d, 8'h49);
      chk({hv, mode}, 8'h00);
      // readback under random enables, with both extremes first
      for (i = 0; i < 10; i++)
      begin
         e = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : $random(seed);
         @(posedge clk) ext <= $random(seed);
         wr(8'h0f, e);
         repeat (3) @(posedge clk);
         rd(8'h0e, ext & e);
         rd(8'h0f, e);
         chk(ien, e);
      end
      wr(8'h0e, ~ext);
      wr(8'h20, 8'h55);
      rd(8'h0e, ext & e);
      rd(8'h20, 8'h00);
      // every source and select code of pin 0
      for (s = 0; s < 8; s++)
         for (l = 0; l < 8; l++)
         begin
            v = $random(seed);
            rnd_status;
            wr({l[2:0], s[2:0], v, 1'b1}, 8'h00);
            wr(8'h10, {l[2:0], s[2:0], v, 1'b1});
            @(posedge clk);
            #1 chk(p0d, exp_pin0(s[2:0], l[2:0], v));
            chk(p0oe, 1'b0);
            if (l == s)
               rd(8'h10, {l[2:0], s[2:0], v, 1'b1});
         end
      // released pin is sensed from outside, then pulled up, then driven low by the device
      wr(8'h0f, 8'hff);
      ext <= 8'h5a;
      wr(8'h10, 8'h92);
      @(posedge clk);
      #1 chk({p0oe, p0d}, 8'h02);
      repeat (3) @(posedge clk);
      rd(8'h0e, 8'h5a);
      @(posedge clk) ext0 <= 1'b0;
      repeat (3) @(posedge clk);
      rd(8'h0e, 8'h5b);
      wr(8'h10, 8'h11);
      repeat (4) @(posedge clk);
      rd(8'h0e, 8'h5a);
      // outside now pulls low, so only the device can raise the pin
      @(posedge clk) ext0 <= 1'b1;
      wr(8'h10, 8'h13);
      repeat (4) @(posedge clk);
      rd(8'h0e, 8'h5b);
      close_out;
   end
endmodule
